// ===== verilog/olc_pkg.sv
`default_nettype none
package olc_pkg;
    // Register indices; byte address is index times four
    localparam logic [7:0] OLC_IDX_PWDN = 8'h1E;
    localparam logic [7:0] OLC_IDX_CH0  = 8'h1F;
    localparam logic [7:0] OLC_IDX_CH1  = 8'h20;
    localparam logic [7:0] OLC_IDX_DIV  = 8'h21;
    localparam int         OLC_WIDX_HI  = 9;
    localparam int         OLC_WIDX_LO  = 2;
    localparam int         OLC_ADDR_HI  = 31;
    localparam int         OLC_ADDR_TOP = 10;

    // Control register field positions
    localparam int OLC_RSV7_BIT = 7;
    localparam int OLC_FMT_HI   = 6;
    localparam int OLC_FMT_LO   = 5;
    localparam int OLC_M1_HI    = 4;
    localparam int OLC_M1_LO    = 3;
    localparam int OLC_M2_HI    = 2;
    localparam int OLC_M2_LO    = 1;
    localparam int OLC_PWDN_BIT = 0;

    // Reset values
    localparam logic [1:0] OLC_FMT_RST  = 2'h1;
    localparam logic [1:0] OLC_M1_RST   = 2'h2;
    localparam logic [1:0] OLC_M2_RST   = 2'h0;
    localparam logic       OLC_RSV7_RST = 1'h1;
    localparam logic [7:0] OLC_DIV_RST  = 8'h01;
    localparam logic       OLC_PWDN_RST = 1'h0;

    typedef enum logic [1:0] {
        OLC_FMT_OFF  = 2'h0,
        OLC_FMT_DIFF = 2'h1,
        OLC_FMT_HCSL = 2'h2,
        OLC_FMT_CMOS = 2'h3
    } olc_fmt_t;

    // Mode codes: CMOS pin behaviour, diff current and load
    localparam logic [1:0] OLC_PIN_TRI  = 2'h0;
    localparam logic [1:0] OLC_PIN_LOW  = 2'h1;
    localparam logic [1:0] OLC_PIN_INV  = 2'h2;
    localparam logic [1:0] OLC_PIN_TRUE = 2'h3;
    localparam logic [4:0] OLC_MA_4     = 5'h04;
    localparam logic [4:0] OLC_MA_6     = 5'h06;
    localparam logic [4:0] OLC_MA_8     = 5'h08;
    localparam logic [4:0] OLC_MA_16    = 5'h10;
    localparam logic [7:0] OLC_OHM_50   = 8'h32;
    localparam logic [7:0] OLC_OHM_100  = 8'h64;
    localparam logic [7:0] OLC_OHM_200  = 8'hC8;
    localparam int         OLC_NCH      = 2;
endpackage
`default_nettype wire

// ===== verilog/olc_div.sv
`timescale 1ns/10ps
`default_nettype none
module olc_div
    import olc_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] div_val_i,
    input  wire logic       pwdn_i,
    output logic            phase_o,
    output logic            tick_o
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       phase;
        logic       tick;
    } olc_div_st_t;

    olc_div_st_t st_r;
    olc_div_st_t st_nxt;
    logic [8:0]  half;

    always_comb
    begin
        st_nxt = st_r;
        half   = ({1'b0, div_val_i} + 9'h001) >> 1;
        if (pwdn_i)
        begin
            st_nxt = '0;
        end
        else
        begin
            // Ratio is field plus one, odd ratios allowed
            if (st_r.cnt >= div_val_i)
                st_nxt.cnt = 8'h00;
            else
                st_nxt.cnt = st_r.cnt + 8'h01;
            st_nxt.tick  = (st_nxt.cnt == 8'h00);
            st_nxt.phase = ({1'b0, st_nxt.cnt} < half);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign phase_o = st_r.phase;
    assign tick_o  = st_r.tick;
endmodule
`default_nettype wire

// ===== verilog/olc_chan.sv
`timescale 1ns/10ps
`default_nettype none
module olc_chan
    import olc_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [1:0] fmt_i,
    input  wire logic [1:0] m1_i,
    input  wire logic [1:0] m2_i,
    input  wire logic       pwdn_i,
    input  wire logic       phase_i,
    output logic            buf_en_o,
    output logic            mux_en_o,
    output logic [4:0]      tail_ma_o,
    output logic [7:0]      rload_ohm_o,
    output logic            p_oe_o,
    output logic            p_o,
    output logic            n_oe_o,
    output logic            n_o
);
    typedef struct packed {
        logic       buf_en;
        logic       mux_en;
        logic [4:0] tail;
        logic [7:0] rload;
        logic       p_oe;
        logic       p;
        logic       n_oe;
        logic       n;
    } olc_chan_st_t;

    olc_chan_st_t st_r;
    olc_chan_st_t st_nxt;
    olc_fmt_t     fmt;

    always_comb
    begin
        st_nxt        = '0;
        fmt           = olc_fmt_t'(fmt_i);
        st_nxt.buf_en = (fmt != OLC_FMT_OFF);
        st_nxt.mux_en = !pwdn_i && (fmt != OLC_FMT_OFF);
        case (fmt)
            OLC_FMT_DIFF, OLC_FMT_HCSL:
            begin
                case (m1_i)
                    2'h0:    st_nxt.tail = OLC_MA_4;
                    2'h1:    st_nxt.tail = OLC_MA_6;
                    2'h2:    st_nxt.tail = OLC_MA_8;
                    default: st_nxt.tail = (fmt == OLC_FMT_HCSL) ? OLC_MA_16 : OLC_MA_8;
                endcase
                if (fmt == OLC_FMT_HCSL)
                begin
                    case (m2_i)
                        2'h0:    st_nxt.rload = 8'h00;
                        2'h1:    st_nxt.rload = OLC_OHM_50;
                        2'h2:    st_nxt.rload = OLC_OHM_100;
                        default: st_nxt.rload = OLC_OHM_200;
                    endcase
                end
            end
            OLC_FMT_CMOS:
            begin
                // Each pin: tri, low, inverted clock or true clock
                st_nxt.p_oe = (m1_i != OLC_PIN_TRI);
                st_nxt.p    = (m1_i == OLC_PIN_TRUE) ? phase_i :
                              (m1_i == OLC_PIN_INV) ? !phase_i : 1'b0;
                st_nxt.n_oe = (m2_i != OLC_PIN_TRI);
                st_nxt.n    = (m2_i == OLC_PIN_TRUE) ? phase_i :
                              (m2_i == OLC_PIN_INV) ? !phase_i : 1'b0;
            end
            default:
            begin
                st_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign buf_en_o    = st_r.buf_en;
    assign mux_en_o    = st_r.mux_en;
    assign tail_ma_o   = st_r.tail;
    assign rload_ohm_o = st_r.rload;
    assign p_oe_o      = st_r.p_oe;
    assign p_o         = st_r.p;
    assign n_oe_o      = st_r.n_oe;
    assign n_o         = st_r.n;
endmodule
`default_nettype wire

// ===== verilog/olc_regs.sv
`timescale 1ns/10ps
`default_nettype none
module olc_regs
    import olc_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o,
    output logic [1:0]       ch_fmt_o [OLC_NCH],
    output logic [7:0]       div_val_o,
    output logic             pwdn_o,
    output logic             div_phase_o,
    output logic             div_tick_o,
    output logic [1:0]       buf_en_o,
    output logic [1:0]       mux_en_o,
    output logic [4:0]       tail_ma_o [OLC_NCH],
    output logic [7:0]       rload_ohm_o [OLC_NCH],
    output logic [1:0]       p_oe_o,
    output logic [1:0]       p_o,
    output logic [1:0]       n_oe_o,
    output logic [1:0]       n_o
);
    typedef struct packed {
        logic       ch0_rsv7;
        logic [1:0] ch0_fmt;
        logic [1:0] ch0_m1;
        logic [1:0] ch0_m2;
        logic [1:0] ch1_fmt;
        logic [1:0] ch1_m1;
        logic [1:0] ch1_m2;
        logic [7:0] div;
        logic       pwdn;
        logic       wr_pend;
        logic [7:0] wr_idx;
        logic [31:0] rdata;
        logic       readyout;
    } olc_regs_st_t;

    olc_regs_st_t st_r;
    olc_regs_st_t st_nxt;
    logic         addr_ok;
    logic [7:0]   widx;
    logic         take;
    logic [7:0]   wb;

    always_comb
    begin
        st_nxt  = st_r;
        wb      = hwdata_i[7:0];
        widx    = haddr_i[OLC_WIDX_HI:OLC_WIDX_LO];
        addr_ok = (haddr_i[OLC_ADDR_HI:OLC_ADDR_TOP] == '0);
        take    = hsel_i && hready_i && htrans_i[1];

        // Data phase of a write commits this cycle
        if (st_r.wr_pend)
        begin
            case (st_r.wr_idx)
                OLC_IDX_CH0:
                begin
                    st_nxt.ch0_rsv7 = wb[OLC_RSV7_BIT];
                    st_nxt.ch0_fmt  = wb[OLC_FMT_HI:OLC_FMT_LO];
                    st_nxt.ch0_m1   = wb[OLC_M1_HI:OLC_M1_LO];
                    st_nxt.ch0_m2   = wb[OLC_M2_HI:OLC_M2_LO];
                end
                OLC_IDX_CH1:
                begin
                    st_nxt.ch1_fmt = wb[OLC_FMT_HI:OLC_FMT_LO];
                    st_nxt.ch1_m1  = wb[OLC_M1_HI:OLC_M1_LO];
                    st_nxt.ch1_m2  = wb[OLC_M2_HI:OLC_M2_LO];
                end
                OLC_IDX_DIV:
                begin
                    st_nxt.div = wb;
                end
                OLC_IDX_PWDN:
                begin
                    st_nxt.pwdn = wb[OLC_PWDN_BIT];
                end
                default:
                begin
                    st_nxt.wr_idx = st_r.wr_idx;
                end
            endcase
        end

        st_nxt.wr_pend  = take && hwrite_i && addr_ok;
        st_nxt.wr_idx   = widx;
        st_nxt.readyout = 1'b1;

        // Read data built from post-write values so back-to-back reads see new data
        if (take && !hwrite_i)
        begin
            st_nxt.rdata = 32'h0000_0000;
            if (addr_ok)
            begin
                case (widx)
                    OLC_IDX_CH0:
                    begin
                        st_nxt.rdata[OLC_RSV7_BIT]          = st_nxt.ch0_rsv7;
                        st_nxt.rdata[OLC_FMT_HI:OLC_FMT_LO] = st_nxt.ch0_fmt;
                        st_nxt.rdata[OLC_M1_HI:OLC_M1_LO]   = st_nxt.ch0_m1;
                        st_nxt.rdata[OLC_M2_HI:OLC_M2_LO]   = st_nxt.ch0_m2;
                    end
                    OLC_IDX_CH1:
                    begin
                        st_nxt.rdata[OLC_FMT_HI:OLC_FMT_LO] = st_nxt.ch1_fmt;
                        st_nxt.rdata[OLC_M1_HI:OLC_M1_LO]   = st_nxt.ch1_m1;
                        st_nxt.rdata[OLC_M2_HI:OLC_M2_LO]   = st_nxt.ch1_m2;
                    end
                    OLC_IDX_DIV:
                    begin
                        st_nxt.rdata[7:0] = st_nxt.div;
                    end
                    OLC_IDX_PWDN:
                    begin
                        st_nxt.rdata[OLC_PWDN_BIT] = st_nxt.pwdn;
                    end
                    default:
                    begin
                        st_nxt.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_r          <= '0;
            st_r.ch0_rsv7 <= OLC_RSV7_RST;
            st_r.ch0_fmt  <= OLC_FMT_RST;
            st_r.ch0_m1   <= OLC_M1_RST;
            st_r.ch0_m2   <= OLC_M2_RST;
            st_r.ch1_fmt  <= OLC_FMT_RST;
            st_r.ch1_m1   <= OLC_M1_RST;
            st_r.ch1_m2   <= OLC_M2_RST;
            st_r.div      <= OLC_DIV_RST;
            st_r.pwdn     <= OLC_PWDN_RST;
            st_r.readyout <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // One divider feeds both channels
    olc_div u_div (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .div_val_i (st_r.div),
        .pwdn_i    (st_r.pwdn),
        .phase_o   (div_phase_o),
        .tick_o    (div_tick_o)
    );

    logic [1:0] fmt_a [OLC_NCH];
    logic [1:0] m1_a  [OLC_NCH];
    logic [1:0] m2_a  [OLC_NCH];

    assign fmt_a[0] = st_r.ch0_fmt;
    assign fmt_a[1] = st_r.ch1_fmt;
    assign m1_a[0]  = st_r.ch0_m1;
    assign m1_a[1]  = st_r.ch1_m1;
    assign m2_a[0]  = st_r.ch0_m2;
    assign m2_a[1]  = st_r.ch1_m2;

    genvar gi;
    generate
        for (gi = 0; gi < OLC_NCH; gi++)
        begin : g_ch
            olc_chan u_chan (
                .ref_clk_i   (ref_clk_i),
                .rst_n_i     (rst_n_i),
                .fmt_i       (fmt_a[gi]),
                .m1_i        (m1_a[gi]),
                .m2_i        (m2_a[gi]),
                .pwdn_i      (st_r.pwdn),
                .phase_i     (div_phase_o),
                .buf_en_o    (buf_en_o[gi]),
                .mux_en_o    (mux_en_o[gi]),
                .tail_ma_o   (tail_ma_o[gi]),
                .rload_ohm_o (rload_ohm_o[gi]),
                .p_oe_o      (p_oe_o[gi]),
                .p_o         (p_o[gi]),
                .n_oe_o      (n_oe_o[gi]),
                .n_o         (n_o[gi])
            );
        end
    endgenerate

    assign ch_fmt_o[0] = st_r.ch0_fmt;
    assign ch_fmt_o[1] = st_r.ch1_fmt;
    assign div_val_o   = st_r.div;
    assign pwdn_o      = st_r.pwdn;
    assign hreadyout_o = st_r.readyout;
    // Only OKAY responses exist in this slave
    assign hresp_o     = 1'b0;
    assign hrdata_o    = st_r.rdata;
endmodule
`default_nettype wire

// ===== bench/olc_regs_checker.sv
`timescale 1ns/10ps
`default_nettype none
module olc_regs_checker
    import olc_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        hreadyout_o,
    input  wire logic        hresp_o,
    input  wire logic [31:0] hrdata_o,
    input  wire logic [1:0]  ch_fmt_o [OLC_NCH],
    input  wire logic [7:0]  div_val_o,
    input  wire logic        pwdn_o,
    input  wire logic        div_phase_o,
    input  wire logic        div_tick_o,
    input  wire logic [1:0]  buf_en_o,
    input  wire logic [1:0]  mux_en_o,
    input  wire logic [4:0]  tail_ma_o [OLC_NCH],
    input  wire logic [7:0]  rload_ohm_o [OLC_NCH],
    input  wire logic [1:0]  p_oe_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    chk_ready_zero_wait: assert property (hreadyout_o)
        else $error("hreadyout low");
    chk_resp_okay: assert property (!hresp_o)
        else $error("error response");
    chk_rdata_upper_zero: assert property (hrdata_o[31:8] == 24'h000000)
        else $error("read data upper bits set");
    // Guarded by past reset: decoded outputs lag the field by one edge
    chk_buf_fmt: assert property ($past(rst_n_i) |-> buf_en_o[0] == ($past(ch_fmt_o[0]) != 2'h0))
        else $error("buffer enable does not follow format");
    chk_mux_pwdn: assert property (pwdn_o && $past(pwdn_o) |-> mux_en_o == 2'h0)
        else $error("mux enabled in powerdown");
    chk_div_stopped: assert property (pwdn_o && $past(pwdn_o) |-> !div_tick_o && !div_phase_o)
        else $error("divider runs in powerdown");
    chk_tick_gap: assert property (div_tick_o && !pwdn_o && div_val_o != 8'h00 && $stable(div_val_o)
        ##1 $stable(div_val_o) |-> !div_tick_o)
        else $error("divider ticks on adjacent cycles");
    chk_cmos_oe_fmt: assert property (p_oe_o[1] |-> $past(ch_fmt_o[1]) == 2'h3 || $past(ch_fmt_o[1], 2) == 2'h3)
        else $error("pin enabled outside CMOS format");
    chk_load_hcsl: assert property (rload_ohm_o[0] != 8'h00 |-> ch_fmt_o[0] == 2'h2 || $past(ch_fmt_o[0]) == 2'h2)
        else $error("load set outside HCSL format");
    chk_tail_off: assert property ($past(rst_n_i) && ch_fmt_o[0] == 2'h0 && $past(ch_fmt_o[0]) == 2'h0
        |-> tail_ma_o[0] == 5'h00)
        else $error("tail current in disabled format");

    cover property (pwdn_o && $past(pwdn_o));
    cover property (p_oe_o[1]);
    cover property (rload_ohm_o[0] == 8'hC8);
endmodule

bind olc_regs olc_regs_checker u_chk (.ref_clk_i, .rst_n_i, .hreadyout_o, .hresp_o, .hrdata_o, .ch_fmt_o,
    .div_val_o, .pwdn_o, .div_phase_o, .div_tick_o, .buf_en_o, .mux_en_o, .tail_ma_o, .rload_ohm_o, .p_oe_o);
`default_nettype wire

// ===== bench/olc_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module olc_regs_tb
    import olc_pkg::*;
;
    localparam logic [31:0] AC0 = {22'h0, OLC_IDX_CH0, 2'h0};
    localparam logic [31:0] AC1 = {22'h0, OLC_IDX_CH1, 2'h0};
    localparam logic [31:0] ADV = {22'h0, OLC_IDX_DIV, 2'h0};
    localparam logic [31:0] APD = {22'h0, OLC_IDX_PWDN, 2'h0};
    logic        clk;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hready;
    logic        hresp;
    logic [31:0] hrdata;
    logic [1:0]  fmt [OLC_NCH];
    logic [7:0]  dval;
    logic        pwdn;
    logic        phase;
    logic        tick;
    logic [1:0]  buf_en;
    logic [1:0]  mux_en;
    logic [4:0]  tail [OLC_NCH];
    logic [7:0]  rload [OLC_NCH];
    logic [1:0]  p_oe;
    logic [1:0]  p_lv;
    logic [1:0]  n_oe;
    logic [1:0]  n_lv;
    logic [31:0] rd;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cyc = 0;

    olc_regs DUT (.ref_clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
        .hresp_o(hresp), .hrdata_o(hrdata), .ch_fmt_o(fmt), .div_val_o(dval), .pwdn_o(pwdn),
        .div_phase_o(phase), .div_tick_o(tick), .buf_en_o(buf_en), .mux_en_o(mux_en), .tail_ma_o(tail),
        .rload_ohm_o(rload), .p_oe_o(p_oe), .p_o(p_lv), .n_oe_o(n_oe), .n_o(n_lv));

    task automatic summarize();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        if (got !== exp)
            num_errors++;
    endtask

    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask

    task automatic t_reset();
        rchk(AC0, 32'h000000B0);
        rchk(AC1, 32'h00000030);
        rchk(ADV, 32'h00000001);
        rchk(APD, 32'h00000000);
        chk(32'(buf_en), 32'h3);
        chk(32'({fmt[0], fmt[1]}), 32'h5);
        chk(32'({tail[0], tail[1]}), 32'h108);
        chk(32'({rload[0], rload[1], hresp}), 32'h0);
        $display("reset values done");
    endtask

    task automatic t_rw();
        bus(AC0, 1'b1, 32'hFFFFFFFF);
        rchk(AC0, 32'h000000FE);
        bus(AC1, 1'b1, 32'hFFFFFFFF);
        rchk(AC1, 32'h0000007E);
        bus(AC0, 1'b1, 32'h0);
        rchk(AC0, 32'h0);
        bus(32'h88, 1'b1, 32'hFFFFFFFF);
        rchk(32'h88, 32'h0);
        bus(AC0 | 32'h400, 1'b1, 32'hFFFFFFFF);
        rchk(AC0, 32'h0);
        $display("read write done");
    endtask

    task automatic t_fmt();
        logic [4:0] ma [4] = '{5'h04, 5'h06, 5'h08, 5'h08};
        logic [7:0] ohm [4] = '{8'h00, 8'h32, 8'h64, 8'hC8};
        for (int f = 1; f < 3; f++)
            for (int m = 0; m < 4; m++)
            begin
                bus(AC0, 1'b1, 32'({f[1:0], m[1:0], m[1:0], 1'b0}));
                repeat (3) @(posedge clk);
                chk(32'(tail[0]), (f == 2 && m == 3) ? 32'h10 : 32'(ma[m]));
                chk(32'(rload[0]), (f == 2) ? 32'(ohm[m]) : 32'h0);
            end
        bus(AC0, 1'b1, 32'h0);
        repeat (3) @(posedge clk);
        chk(32'({buf_en[0], mux_en[0], tail[0]}), 32'h0);
        $display("format decode done");
    endtask

    task automatic t_cmos();
        logic [7:0] pin [4] = '{8'h00, 8'h88, 8'hAA, 8'h88};
        int t;
        bus(ADV, 1'b1, 32'h0);
        for (int m = 0; m < 4; m++)
        begin
            bus(AC1, 1'b1, 32'({2'h3, m[1:0], m[1:0], 1'b0}));
            repeat (3) @(posedge clk);
            // Ratio one holds phase low, so only inverted mode drives high
            chk(32'({p_oe, p_lv, n_oe, n_lv}), 32'(pin[m]));
        end
        // Ratio two toggles phase: true and inverted pins stay opposite
        bus(ADV, 1'b1, 32'h1);
        bus(AC1, 1'b1, 32'h7C);
        repeat (3) @(posedge clk);
        t = 0;
        repeat (4)
        begin
            @(posedge clk);
            t += int'(p_lv[1]);
            chk(32'(p_lv[1] ^ n_lv[1]), 32'h1);
        end
        chk(32'(t), 32'h2);
        $display("cmos pins done");
    endtask

    task automatic t_div();
        int n [4] = '{0, 3, 4, 255};
        int t;
        int h;
        for (int i = 0; i < 4; i++)
        begin
            bus(ADV, 1'b1, 32'(n[i]));
            rchk(ADV, 32'(n[i]));
            chk(32'(dval), 32'(n[i]));
            repeat (2 * n[i] + 8) @(posedge clk);
            t = 0;
            h = 0;
            repeat (4 * (n[i] + 1))
            begin
                @(posedge clk);
                t += int'(tick);
                h += int'(phase);
            end
            chk(32'(t), 32'h4);
            chk(32'(h), 32'(4 * ((n[i] + 1) / 2)));
        end
        $display("divider ratio done");
    endtask

    task automatic t_pwdn();
        int t;
        bus(ADV, 1'b1, 32'h1);
        bus(AC0, 1'b1, 32'h20);
        bus(APD, 1'b1, 32'h1);
        repeat (3) @(posedge clk);
        t = 0;
        repeat (10)
        begin
            @(posedge clk);
            t += int'(tick);
        end
        chk(32'({buf_en, mux_en}), 32'hC);
        chk(32'(t), 32'h0);
        rchk(APD, 32'h1);
        bus(APD, 1'b1, 32'h0);
        repeat (3) @(posedge clk);
        chk(32'(mux_en), 32'h3);
        $display("powerdown done");
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 12000)
        begin
            num_errors++;
            summarize();
        end
    end

    initial
    begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_rw();
        t_fmt();
        t_cmos();
        t_div();
        t_pwdn();
        summarize();
    end
endmodule
`default_nettype wire
